// file: hdl/nvc_arbiter.sv
`timescale 1ns/10ps
module nvc_arbiter #(
  parameter int N = 33,
  parameter int W = 6,
  parameter int IW = 6
) (
  input  wire logic [N-1:0]        req,     // Candidate positions.
  input  wire logic [N-1:0][W-1:0] prio,    // Effective priority per position.
  output logic                     found,   // Some candidate is present.
  output logic [IW-1:0]            winIdx,  // Winning table position.
  output logic [W-1:0]             winPrio  // Priority of the winner.
);
  import nvc_pkg::*;

  initial begin
    if (N > (1 << IW)) begin
      $error("nvc_arbiter: index width too small");
    end
  end

  // ---------------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------------
  // Scan from low positions upward; only a strictly better priority displaces
  // the held winner, so ties go to the lower position.
  always_comb begin
    found   = 1'b0;
    winIdx  = '0;
    winPrio = '1;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || (prio[i] < winPrio))) begin
        found   = 1'b1;
        winIdx  = IW'(i);
        winPrio = prio[i];
      end
    end
  end
endmodule

// file: hdl/nvc_controller.sv
`timescale 1ns/10ps
`include "nvc_map.svh"

// Contract
// - After reset the stack pointer entry zero is fetched before the reset vector.
// - Reset is position 1, asynchronous, dropping to thread level at first instruction.
// - The non-maskable exception, position 2, is preempted only by reset.
// - Faults unable to activate by priority or disabled handler raise hard fault; an imprecise bus fault escalates only when its handler is disabled.
// - Memory protection mismatch raises the memory fault at position 4.
// - Address faults raise bus fault at position 5, precise or imprecise.
// - Undefined instruction or illegal state raises usage fault at position 6.
// - Supervisor call instruction raises the service exception at position 11.
// - Debug monitor, position 12, only when enabled and of higher priority.
// - Pendable service exception, position 14, is pended only by software.
// - System tick expiry raises the tick exception at position 15.
// - Peripheral interrupts fill positions 18 to 32; 22, 27 and 29 are reserved.
// - Reset, non-maskable, hard fault hold fixed top priorities in that order.
// - Other exceptions use a 5-bit software priority, lower value more urgent.
// - Equal software priority is served by lower table position first.
// - Zero bits written to set, clear or active registers do nothing.
// - Enable-set one enables an interrupt; enable-clear one disables it.
// - Pend-set one sets the pending latch; pend-clear one clears it.
// - Active indication is read-only and reflects currently active interrupts.
// - Enable masks the pending latch output; disabled pended interrupts are not taken.
// - A pended interrupt stays pending and is taken once enabled later.
// - Peripheral request lines are level sensitive and held until removed.
module nvc_controller #(
  parameter int NUM_IRQ = 17,
  parameter int PRIO_W  = 5
) (
  input  wire logic                              clock,      // System clock, 40 MHz.
  input  wire logic                              reset_n,    // Asynchronous reset, low.
  input  wire logic [NUM_IRQ-1:0]                periphIrq,  // Peripheral level lines.
  input  wire nvc_pkg::nvc_sw_wr_s               swWr,       // Software set/clear strobes.
  input  wire nvc_pkg::nvc_sys_evt_s             sysEvt,     // System event pulses.
  input  wire nvc_pkg::nvc_cfg_s                 cfg,        // Handler enables.
  input  wire logic [`NVC_NUM_POS-1:0][PRIO_W-1:0] swPrio,   // Software priorities.
  input  wire logic                              bootAck,    // Core took a vector fetch.
  input  wire logic                              firstInstr, // Reset handler started.
  input  wire logic                              excAck,     // Core takes excNum.
  input  wire logic                              excReturn,  // Core leaves a handler.
  output logic                                   vecFetch,   // Boot vector fetch request.
  output nvc_pkg::nvc_pos_t                      vecIdx,     // Boot vector entry.
  output logic                                   excReq,     // Exception request.
  output nvc_pkg::nvc_pos_t                      excNum,     // Requested position.
  output nvc_pkg::nvc_eprio_t                    curPrio,    // Running priority.
  output nvc_pkg::nvc_irq_t                      irqEnable,  // Enable mask view.
  output nvc_pkg::nvc_irq_t                      irqPending, // Pending latch view.
  output nvc_pkg::nvc_irq_t                      irqActive   // Active indication.
);
  import nvc_pkg::*;

  initial begin
    if (NUM_IRQ != `NVC_NUM_IRQ || PRIO_W != 5) begin
      $error("nvc_controller: unsupported NUM_IRQ or PRIO_W");
    end
  end

  // ---------------------------------------------------------------------------
  // Priority helpers
  // ---------------------------------------------------------------------------
  // Fixed codes for the top three, software value offset for the rest.
  function automatic nvc_eprio_t effPrio(input int pos, input logic [PRIO_W-1:0] p);
    case (pos)
      `NVC_POS_RESET:     effPrio = `NVC_EPRIO_RESET;
      `NVC_POS_NMI:       effPrio = `NVC_EPRIO_NMI;
      `NVC_POS_HARDFAULT: effPrio = `NVC_EPRIO_HARD;
      default: effPrio = `NVC_EPRIO_SWBASE + nvc_eprio_t'(p);
    endcase
  endfunction

  localparam nvc_irq_t VALID = ~`NVC_IRQ_RSVD;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  nvc_boot_e                         state_q;
  nvc_irq_t                          enable_q;
  logic [`NVC_NUM_POS-1:0]           pend_q;
  logic [`NVC_NUM_POS-1:0]           active_q;
  logic [`NVC_NUM_POS-1:0]           pendSet;
  logic [`NVC_NUM_POS-1:0]           pendClr;
  logic [`NVC_NUM_POS-1:0]           gate;
  logic [`NVC_NUM_POS-1:0][5:0]      ePrio;
  logic                              pFound;
  logic                              aFound;
  nvc_pos_t                          pIdx;
  nvc_pos_t                          aIdx;
  nvc_eprio_t                        pPrio;
  nvc_eprio_t                        aPrio;
  nvc_eprio_t                        runPrio;
  logic                              excReq_q;
  nvc_pos_t                          excNum_q;
  nvc_pos_t                          vecIdx_q;
  nvc_eprio_t                        curPrio_q;
  logic                              memHard;
  logic                              busHard;
  logic                              usageHard;
  logic                              dbgTake;

  always_comb begin
    for (int i = 0; i < `NVC_NUM_POS; i++) begin
      ePrio[i] = effPrio(i, swPrio[i]);
    end
  end

  // ---------------------------------------------------------------------------
  // Boot sequence
  // ---------------------------------------------------------------------------
  // Entry zero, then entry one, then hold reset level until the handler runs.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= ST_LOAD_SP;
      vecIdx_q <= `NVC_POS_SP;
    end else begin
      case (state_q)
        ST_LOAD_SP: begin
          if (bootAck) begin
            state_q  <= ST_LOAD_RESET;
            vecIdx_q <= `NVC_POS_RESET;
          end
        end
        ST_LOAD_RESET: begin
          if (bootAck) begin
            state_q <= ST_RESET_ACT;
          end
        end
        ST_RESET_ACT: begin
          if (firstInstr) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_LOAD_SP;
        end
      endcase
    end
  end

  assign vecFetch = (state_q == ST_LOAD_SP) || (state_q == ST_LOAD_RESET);
  assign vecIdx   = vecIdx_q;

  // ---------------------------------------------------------------------------
  // Running priority
  // ---------------------------------------------------------------------------
  // Until the reset handler starts, reset level blocks every other exception.
  always_comb begin
    if (state_q != ST_RUN) begin
      runPrio = `NVC_EPRIO_RESET;
    end else if (aFound) begin
      runPrio = aPrio;
    end else begin
      runPrio = `NVC_EPRIO_THREAD;
    end
  end

  // ---------------------------------------------------------------------------
  // Fault escalation
  // ---------------------------------------------------------------------------
  // A synchronous fault that cannot preempt now, or whose handler is off,
  // becomes a hard fault.
  assign memHard   = sysEvt.memFault &&
                     (!cfg.memFaultEn || ePrio[`NVC_POS_MEMFAULT] >= runPrio);
  assign busHard   = (sysEvt.busPrecise &&
                      (!cfg.busFaultEn || ePrio[`NVC_POS_BUSFAULT] >= runPrio)) ||
                     (sysEvt.busImprecise && !cfg.busFaultEn);
  assign usageHard = sysEvt.usageFault &&
                     (!cfg.usageFaultEn || ePrio[`NVC_POS_USAGE] >= runPrio);
  assign dbgTake   = sysEvt.debugMon && cfg.debugMonEn &&
                     (ePrio[`NVC_POS_DBGMON] < runPrio);

  // ---------------------------------------------------------------------------
  // Pending sources
  // ---------------------------------------------------------------------------
  always_comb begin
    pendSet = '0;
    pendSet[`NVC_POS_NMI]       = sysEvt.nmiReq;
    pendSet[`NVC_POS_HARDFAULT] = memHard || busHard || usageHard;
    pendSet[`NVC_POS_MEMFAULT]  = sysEvt.memFault && !memHard;
    pendSet[`NVC_POS_BUSFAULT]  = (sysEvt.busPrecise || sysEvt.busImprecise) &&
                                  !busHard;
    pendSet[`NVC_POS_USAGE]     = sysEvt.usageFault && !usageHard;
    pendSet[`NVC_POS_SVC]       = sysEvt.svcExec;
    pendSet[`NVC_POS_DBGMON]    = dbgTake;
    pendSet[`NVC_POS_PENDABLE_SERVICE_EXCEPTION]    = swWr.pendSvSet;
    pendSet[`NVC_POS_TICK]      = sysEvt.tickExpire;
    pendSet[`NVC_NUM_POS-1:`NVC_POS_IRQ0] =
      (periphIrq | swWr.pendSet) & VALID;
  end

  // Software clear strobes laid out by table position.
  always_comb begin
    pendClr = '0;
    pendClr[`NVC_POS_PENDABLE_SERVICE_EXCEPTION] = swWr.pendSvClr;
    pendClr[`NVC_NUM_POS-1:`NVC_POS_IRQ0] = swWr.pendClr;
  end

  // ---------------------------------------------------------------------------
  // Pending latches
  // ---------------------------------------------------------------------------
  // Cleared by the take or by software; a set in the same cycle wins.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= `NVC_POS_RESETVAL;
    end else begin
      for (int i = 0; i < `NVC_NUM_POS; i++) begin
        if (pendSet[i]) begin
          pend_q[i] <= 1'b1;
        end else if (excAck && excReq_q && excNum_q == nvc_pos_t'(i)) begin
          pend_q[i] <= 1'b0;
        end else if (pendClr[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Enable mask
  // ---------------------------------------------------------------------------
  // Only one bits act; clear takes precedence over set on the same bit.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= `NVC_IRQ_RESET;
    end else begin
      enable_q <= ((enable_q | swWr.enSet) & ~swWr.enClr) & VALID;
    end
  end

  // The mask gates the latch output; of the system classes only the debug monitor is gated, by its own enable; entries zero and one never pass.
  always_comb begin
    gate = '1;
    gate[`NVC_POS_SP]     = 1'b0;
    gate[`NVC_POS_RESET]  = 1'b0;
    gate[`NVC_POS_DBGMON] = cfg.debugMonEn;
    gate[`NVC_NUM_POS-1:`NVC_POS_IRQ0] = enable_q;
  end

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  nvc_arbiter #(.N(`NVC_NUM_POS), .W(6), .IW(6)) u_pend_arb (
    .req     (pend_q & gate),
    .prio    (ePrio),
    .found   (pFound),
    .winIdx  (pIdx),
    .winPrio (pPrio)
  );

  nvc_arbiter #(.N(`NVC_NUM_POS), .W(6), .IW(6)) u_act_arb (
    .req     (active_q),
    .prio    (ePrio),
    .found   (aFound),
    .winIdx  (aIdx),
    .winPrio (aPrio)
  );

  // Request only what strictly outranks the running level.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      excReq_q  <= 1'b0;
      excNum_q  <= `NVC_POS_SP;
      curPrio_q <= `NVC_EPRIO_RESET;
    end else begin
      excReq_q  <= pFound && (pPrio < runPrio) && !(excAck && excReq_q);
      excNum_q  <= pIdx;
      curPrio_q <= runPrio;
    end
  end

  assign excReq  = excReq_q;
  assign excNum  = excNum_q;
  assign curPrio = curPrio_q;

  // ---------------------------------------------------------------------------
  // Active tracking
  // ---------------------------------------------------------------------------
  // A return retires the innermost handler, which holds the best priority.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= `NVC_POS_RESETVAL;
    end else begin
      for (int i = 0; i < `NVC_NUM_POS; i++) begin
        if (excAck && excReq_q && excNum_q == nvc_pos_t'(i)) begin
          active_q[i] <= 1'b1;
        end else if (excReturn && aFound && aIdx == nvc_pos_t'(i)) begin
          active_q[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------------------
  assign irqEnable  = enable_q;
  assign irqPending = pend_q[`NVC_NUM_POS-1:`NVC_POS_IRQ0] & VALID;
  assign irqActive  = active_q[`NVC_NUM_POS-1:`NVC_POS_IRQ0] & VALID;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_boot_order;
    @(posedge clock) disable iff (!reset_n)
    (state_q == ST_LOAD_SP && bootAck) |=> (vecFetch && vecIdx == `NVC_POS_RESET);
  endproperty
  a_boot_order: assert property (p_boot_order) else $error("stack entry not first");

  property p_no_req_in_reset;
    @(posedge clock) disable iff (!reset_n)
    (state_q != ST_RUN) |=> !excReq_q;
  endproperty
  a_no_req_in_reset: assert property (p_no_req_in_reset) else $error("request during reset");

  property p_nmi_blocks;
    @(posedge clock) disable iff (!reset_n)
    (active_q[`NVC_POS_NMI] && aIdx == `NVC_POS_NMI) |=> !excReq_q;
  endproperty
  a_nmi_blocks: assert property (p_nmi_blocks) else $error("nmi was preempted");

  property p_escalate;
    @(posedge clock) disable iff (!reset_n)
    (sysEvt.usageFault && !cfg.usageFaultEn) |=> pend_q[`NVC_POS_HARDFAULT];
  endproperty
  a_escalate: assert property (p_escalate) else $error("no hard fault escalation");

  property p_enable_set;
    @(posedge clock) disable iff (!reset_n)
    (|(swWr.enSet & ~swWr.enClr & VALID)) |=>
      ((irqEnable & $past(swWr.enSet & ~swWr.enClr & VALID)) ==
       $past(swWr.enSet & ~swWr.enClr & VALID));
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable set lost");

  property p_enable_clr;
    @(posedge clock) disable iff (!reset_n)
    (|swWr.enClr) |=> ((irqEnable & $past(swWr.enClr)) == '0);
  endproperty
  a_enable_clr: assert property (p_enable_clr) else $error("enable clear lost");

  property p_pend_set;
    @(posedge clock) disable iff (!reset_n)
    (|(swWr.pendSet & VALID)) |=>
      ((irqPending & $past(swWr.pendSet & VALID)) == $past(swWr.pendSet & VALID));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pend set lost");

  property p_masked;
    @(posedge clock) disable iff (!reset_n)
    (excReq_q && excNum_q >= `NVC_POS_IRQ0) |->
      |($past(enable_q) & (17'h00001 << (excNum_q - `NVC_POS_IRQ0)));
  endproperty
  a_masked: assert property (p_masked) else $error("disabled irq requested");

  property p_reserved_zero;
    @(posedge clock) disable iff (!reset_n)
    ((irqPending | irqActive | irqEnable) & `NVC_IRQ_RSVD) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
endmodule

// file: hdl/nvc_map.svh
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

// ----------------------------------------------------------------------------
// Exception table positions
// ----------------------------------------------------------------------------
`define NVC_POS_SP        6'h00
`define NVC_POS_RESET     6'h01
`define NVC_POS_NMI       6'h02
`define NVC_POS_HARDFAULT 6'h03
`define NVC_POS_MEMFAULT  6'h04
`define NVC_POS_BUSFAULT  6'h05
`define NVC_POS_USAGE     6'h06
`define NVC_POS_SVC       6'h0B
`define NVC_POS_DBGMON    6'h0C
`define NVC_POS_PENDABLE_SERVICE_EXCEPTION    6'h0E
`define NVC_POS_TICK      6'h0F
`define NVC_POS_IRQ0      6'h10
`define NVC_NUM_POS       33
`define NVC_NUM_IRQ       17

// ----------------------------------------------------------------------------
// Effective priority codes, lower is more urgent
// ----------------------------------------------------------------------------
`define NVC_EPRIO_RESET   6'h00
`define NVC_EPRIO_NMI     6'h01
`define NVC_EPRIO_HARD    6'h02
`define NVC_EPRIO_SWBASE  6'h08
`define NVC_EPRIO_THREAD  6'h3F

// ----------------------------------------------------------------------------
// Peripheral bit layout and reset values
// ----------------------------------------------------------------------------
`define NVC_IRQ_RSVD      17'h02843
`define NVC_IRQ_RESET     17'h00000
`define NVC_POS_RESETVAL  33'h000000000

`endif

// file: hdl/nvc_pkg.sv
package nvc_pkg;
  typedef logic [16:0] nvc_irq_t;
  typedef logic [5:0]  nvc_pos_t;
  typedef logic [5:0]  nvc_eprio_t;

  // Software write strobes; a one bit acts, a zero bit does nothing.
  typedef struct packed {
    nvc_irq_t enSet;
    nvc_irq_t enClr;
    nvc_irq_t pendSet;
    nvc_irq_t pendClr;
    logic     pendSvSet;
    logic     pendSvClr;
  } nvc_sw_wr_s;

  // Core and system event pulses.
  typedef struct packed {
    logic nmiReq;
    logic memFault;
    logic busPrecise;
    logic busImprecise;
    logic usageFault;
    logic svcExec;
    logic debugMon;
    logic tickExpire;
  } nvc_sys_evt_s;

  // Handler enables for configurable classes.
  typedef struct packed {
    logic memFaultEn;
    logic busFaultEn;
    logic usageFaultEn;
    logic debugMonEn;
  } nvc_cfg_s;

  typedef enum logic [3:0] {
    ST_LOAD_SP    = 4'h1,
    ST_LOAD_RESET = 4'h2,
    ST_RESET_ACT  = 4'h4,
    ST_RUN        = 4'h8
  } nvc_boot_e;
endpackage

// file: test/nvc_core_model.sv
`timescale 1ns/10ps
// Behavioural core: fetches the boot vectors, starts the reset handler and takes exceptions.
module nvc_core_model (
  input  wire logic              clock,      // System clock.
  input  wire logic              reset_n,    // Asynchronous reset, low.
  input  wire logic              vecFetch,   // Boot fetch wanted.
  input  wire nvc_pkg::nvc_pos_t vecIdx,     // Boot vector entry.
  input  wire logic              excReq,     // Exception request.
  input  wire logic              takeEn,     // Core willing to take exceptions.
  input  wire logic [3:0]        slowCyc,    // Cycles of delay before each answer.
  output logic                   bootAck,    // Boot vector consumed.
  output logic                   firstInstr, // First handler instruction.
  output logic                   excAck,     // Exception taken.
  output nvc_pkg::nvc_pos_t      log0,       // Entry of the first boot fetch.
  output nvc_pkg::nvc_pos_t      log1        // Entry of the second boot fetch.
);
  import nvc_pkg::*;
  logic [3:0] cnt;
  logic [1:0] fetches;
  logic       booted;

  // Records each boot entry at the edge that consumes it.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetches <= 2'h0;
    end else if (vecFetch && bootAck) begin
      if (fetches == 2'h0) log0 <= vecIdx;
      else log1 <= vecIdx;
      fetches <= fetches + 2'h1;
    end
  end

  // Answers change after the falling edge and hold over one rising edge.
  always @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {bootAck, excAck, firstInstr, booted, cnt} <= '0;
    end else begin
      {bootAck, excAck, firstInstr} <= 3'h0;
      if (bootAck || excAck) cnt <= 4'h0;
      else if (vecFetch || (excReq && takeEn)) cnt <= cnt + 4'h1;
      if (vecFetch && !bootAck && cnt >= slowCyc) bootAck <= 1'b1;
      if (excReq && takeEn && !excAck && cnt >= slowCyc) excAck <= 1'b1;
      if (!vecFetch && !booted && fetches == 2'h2) begin
        firstInstr <= 1'b1;
        booted     <= 1'b1;
      end
    end
  end
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); err_count++; end end
module tb;
  import nvc_pkg::*;
  logic clock = 0, reset_n = 0, excReturn = 0, takeEn = 0;
  logic bootAck, firstInstr, excAck, vecFetch, excReq;
  logic [3:0] slowCyc = 4'h2;
  logic [16:0] periphIrq = '0;
  logic [32:0][4:0] swPrio = {33{5'h10}};
  nvc_sw_wr_s swWr = '0;
  nvc_sys_evt_s sysEvt = '0;
  nvc_cfg_s cfg = '1;
  nvc_pos_t vecIdx, excNum, log0, log1;
  nvc_eprio_t curPrio;
  nvc_irq_t irqEnable, irqPending, irqActive, expEn, s, c;
  int err_count = 0, checks = 0, seed = 38722, i;

  // ------------------------------------------------------------------
  // Design and core model
  // ------------------------------------------------------------------
  nvc_controller DUT (.clock(clock), .reset_n(reset_n), .periphIrq(periphIrq), .swWr(swWr),
    .sysEvt(sysEvt), .cfg(cfg), .swPrio(swPrio), .bootAck(bootAck), .firstInstr(firstInstr),
    .excAck(excAck), .excReturn(excReturn), .vecFetch(vecFetch), .vecIdx(vecIdx),
    .excReq(excReq), .excNum(excNum), .curPrio(curPrio), .irqEnable(irqEnable),
    .irqPending(irqPending), .irqActive(irqActive));
  nvc_core_model core (.clock(clock), .reset_n(reset_n), .vecFetch(vecFetch), .vecIdx(vecIdx),
    .excReq(excReq), .takeEn(takeEn), .slowCyc(slowCyc), .bootAck(bootAck),
    .firstInstr(firstInstr), .excAck(excAck), .log0(log0), .log1(log1));

  // Clock of 25 ns period.
  always #12.5 clock = ~clock;

  // Next enable mask: clear wins over set, reserved bits stay zero.
  function automatic nvc_irq_t nextEn(nvc_irq_t o, nvc_irq_t st, nvc_irq_t cl);
    return (o | st) & ~cl & ~17'h02843;
  endfunction

  // One-cycle software write pulse.
  task automatic wr4(input nvc_irq_t es, ec, ps, pc);
    @(negedge clock) {swWr.enSet, swWr.enClr, swWr.pendSet, swWr.pendClr} = {es, ec, ps, pc};
    @(negedge clock) swWr = '0;
  endtask

  // Waits a bounded time for a request of the given position.
  task automatic waitNum(input nvc_pos_t n);
    int k;
    for (k = 0; k < 10 && !(excReq === 1'b1 && excNum === n); k++) @(negedge clock);
    `CHK(excReq, 1'b1)
    `CHK(excNum, n)
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog cuts a hang short.
  initial begin
    #(25 * 3000);
    err_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (12) @(negedge clock);
    reset_n = 1;
    for (i = 0; i < 60 && !firstInstr; i++) @(negedge clock);
    repeat (3) @(negedge clock);
    `CHK(log0, 6'h00)
    `CHK(log1, 6'h01)
    `CHK(curPrio, 6'h3F)
    $display("boot test done");
    slowCyc = 4'h0;
    expEn = '0;
    for (i = 0; i < 30; i++) begin
      @(negedge clock);
      if (i > 0) `CHK(irqEnable, expEn)
      s = $random(seed);
      c = $random(seed) & $random(seed);
      {swWr.enSet, swWr.enClr} = {s, c};
      expEn = nextEn(expEn, s, c);
    end
    @(negedge clock) swWr = '0;
    `CHK(irqEnable, expEn)
    wr4('0, '1, '0, '0);
    $display("enable test done");
    wr4('0, '0, 17'h00004, '0);
    repeat (4) @(negedge clock);
    `CHK(irqPending[2], 1'b1)
    `CHK(excReq, 1'b0)
    wr4(17'h00004, '0, '0, '0);
    waitNum(6'h12);
    wr4('0, '0, '0, 17'h00004);
    repeat (3) @(negedge clock);
    `CHK(excReq, 1'b0)
    wr4(17'h05000, '0, 17'h05000, '0);
    waitNum(6'h1C);
    @(negedge clock) swPrio[30] = 5'h04;
    waitNum(6'h1E);
    takeEn = 1;
    repeat (4) @(negedge clock);
    takeEn = 0;
    `CHK(irqActive, 17'h04000)
    `CHK(excReq, 1'b0)
    @(negedge clock) excReturn = 1;
    @(negedge clock) excReturn = 0;
    waitNum(6'h1C);
    `CHK(irqActive, 17'h00000)
    $display("arbitration test done");
    periphIrq = 17'h00050;
    repeat (2) @(negedge clock);
    wr4('0, '0, '0, 17'h00050);
    repeat (2) @(negedge clock);
    `CHK(irqPending[6:4], 3'h1)
    @(negedge clock) swPrio[15] = 5'h00;
    sysEvt.tickExpire = 1;
    @(negedge clock) sysEvt = '0;
    waitNum(6'h0F);
    sysEvt.nmiReq = 1;
    @(negedge clock) sysEvt = '0;
    waitNum(6'h02);
    takeEn = 1;
    repeat (3) @(negedge clock);
    takeEn = 0;
    cfg.usageFaultEn = 0;
    sysEvt.usageFault = 1;
    @(negedge clock) sysEvt = '0;
    repeat (2) @(negedge clock);
    `CHK(excReq, 1'b0)
    @(negedge clock) excReturn = 1;
    @(negedge clock) excReturn = 0;
    waitNum(6'h03);
    $display("system test done");
    tally_and_finish();
  end
endmodule
